// >>> hdl/sld_pkg.sv
// Purpose: shared constants of the segment text_display_write driver
// Assumes: 40 MHz ref_clk, 32-bit APB slave, byte addressed word registers
package sld_pkg;
  // apb address map, byte addresses of aligned words
  localparam logic [7:0]  OFF_TEXT_LO  = 8'h00;  // characters 1 to 4
  localparam logic [7:0]  OFF_TEXT_HI  = 8'h04;  // characters 5 to 8
  localparam logic [7:0]  OFF_TEXT_LEN = 8'h08;  // text length
  localparam logic [7:0]  OFF_FLASH    = 8'h0C;  // flash_mask byte
  localparam logic [7:0]  OFF_SYMBOL   = 8'h10;  // symbol_mask byte
  localparam logic [7:0]  OFF_POINT    = 8'h14;  // decimal point byte
  localparam logic [7:0]  OFF_COMMIT   = 8'h18;  // commit strobe, write only
  localparam logic [7:0]  OFF_STATUS   = 8'h1C;  // block state, read only
  // field positions
  localparam int          COMMIT_BIT   = 0;      // commit request bit
  localparam int          STAT_PHASE   = 0;      // flash phase, 1 = blanked
  localparam int          STAT_PEND    = 1;      // staged data not committed
  localparam int          LEN_W        = 4;      // width of length field
  // display geometry
  localparam int          NUM_CHARS    = 8;      // longest text
  localparam int          NUM_DIGITS   = 5;      // 7-segment digits
  localparam int          NUM_LETTERS  = 3;      // alphanumeric fields
  localparam int          NUM_POINTS   = 5;      // decimal points
  localparam logic [3:0]  MAX_LEN      = 4'h8;   // clamp of the length field
  // reset values
  localparam logic [31:0] RST_TEXT     = 32'h2020_2020;  // all blanks
  localparam logic [3:0]  RST_LEN      = 4'h0;
  localparam logic [7:0]  RST_MASK     = 8'h00;
  localparam logic [7:0]  CHAR_BLANK   = 8'h20;
  // flash timing
  localparam int          CLK_FREQ_HZ  = 40_000_000;
  localparam int          FLASH_HALF_MS = 500;   // half period of the flash
  localparam int          FLASH_HALF_CYC = (CLK_FREQ_HZ / 1000) * FLASH_HALF_MS;
  localparam int          FLASH_CNT_W  = 25;     // holds FLASH_HALF_CYC
endpackage

// >>> hdl/sld_flash_timer.sv
// Purpose: divider giving the slow flash phase of the display
// Assumes: one clock, synchronous active low reset
// Notes:   phase toggles every HALF_CYCLES clocks, roughly one hertz
`timescale 1ns/100ps
module sld_flash_timer #(
  parameter int HALF_CYCLES = sld_pkg::FLASH_HALF_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      flashPhase
);
  logic [sld_pkg::FLASH_CNT_W-1:0] count_reg;   // cycles in this half period
  logic [sld_pkg::FLASH_CNT_W-1:0] count_next;
  logic                            phase_reg;   // 1 while flashing is blank
  logic                            phase_next;
  localparam logic [sld_pkg::FLASH_CNT_W-1:0] LAST =
    sld_pkg::FLASH_CNT_W'(HALF_CYCLES - 1);

  // count to the end of each half period, then flip the phase
  always_comb begin
    count_next = count_reg + 1'b1;
    phase_next = phase_reg;
    if (count_reg >= LAST) begin
      count_next = '0;
      phase_next = ~phase_reg;
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      count_reg <= '0;
      phase_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      phase_reg <= phase_next;
    end
  end

  assign flashPhase = phase_reg;
endmodule // sld_flash_timer

// >>> hdl/sld_font_rom.sv
// Purpose: character to segment pattern lookup with registered output
// Assumes: ascii input, lower case folded to upper case on letters
// Notes:   unknown characters come out blank
`timescale 1ns/100ps
module sld_font_rom (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [63:0] chars,
  output logic      [39:0] digitPattern,
  output logic      [47:0] letterPattern
);
  logic [39:0] digit_reg;   // five 7-segment patterns
  logic [39:0] digit_next;
  logic [47:0] letter_reg;  // three 16-bit alphanumeric patterns
  logic [47:0] letter_next;

  // 7-segment glyphs: e=0 f=1 d=2 g=3 a=4 c=6 b=7, bit 5 unused
  function automatic logic [7:0] font7(input logic [7:0] ch);
    unique case (ch)
      8'h30: font7 = 8'hD7;
      8'h31: font7 = 8'hC0;
      8'h32: font7 = 8'h9D;
      8'h33: font7 = 8'hDC;
      8'h34: font7 = 8'hCA;
      8'h35, 8'h53, 8'h73: font7 = 8'h5E;
      8'h36: font7 = 8'h5F;
      8'h37: font7 = 8'hD0;
      8'h38: font7 = 8'hDF;
      8'h39: font7 = 8'hDE;
      8'h41, 8'h61: font7 = 8'hDB;
      8'h42, 8'h62: font7 = 8'h4F;
      8'h43, 8'h63: font7 = 8'h17;
      8'h44, 8'h64: font7 = 8'hCD;
      8'h45, 8'h65: font7 = 8'h1F;
      8'h46, 8'h66: font7 = 8'h1B;
      8'h48, 8'h68: font7 = 8'hCB;
      8'h4C, 8'h6C: font7 = 8'h07;
      8'h50, 8'h70: font7 = 8'h9B;
      8'h55, 8'h75: font7 = 8'hC7;
      8'h2D: font7 = 8'h08;
      default: font7 = 8'h00;
    endcase
  endfunction

  // 16-bit glyphs: d=0 e=1 f=2 j=4 g=5 m=6 h=7 a=8 n=9 k=10 i=11 c=13 b=14
  function automatic logic [15:0] font16(input logic [7:0] ch);
    logic [7:0] up;
    up = (ch >= 8'h61 && ch <= 8'h7A) ? ch - 8'h20 : ch;
    unique case (up)
      8'h30, 8'h4F: font16 = 16'h6107;
      8'h31: font16 = 16'h6000;
      8'h32: font16 = 16'h4163;
      8'h33: font16 = 16'h6161;
      8'h34: font16 = 16'h6064;
      8'h35, 8'h53: font16 = 16'h2165;
      8'h36: font16 = 16'h2167;
      8'h37: font16 = 16'h6100;
      8'h38: font16 = 16'h6167;
      8'h39: font16 = 16'h6165;
      8'h41: font16 = 16'h6166;
      8'h42: font16 = 16'h6951;
      8'h43: font16 = 16'h0107;
      8'h44: font16 = 16'h6911;
      8'h45: font16 = 16'h0167;
      8'h46: font16 = 16'h0166;
      8'h47: font16 = 16'h2147;
      8'h48: font16 = 16'h6066;
      8'h49: font16 = 16'h0911;
      8'h4A: font16 = 16'h6003;
      8'h4B: font16 = 16'h2466;
      8'h4C: font16 = 16'h0007;
      8'h4D: font16 = 16'h6486;
      8'h4E: font16 = 16'h6086;
      8'h50: font16 = 16'h4166;
      8'h51: font16 = 16'h6117;
      8'h52: font16 = 16'h4176;
      8'h54: font16 = 16'h0910;
      8'h55: font16 = 16'h6007;
      8'h56: font16 = 16'h4206;
      8'h57: font16 = 16'h6216;
      8'h58: font16 = 16'h0690;
      8'h59: font16 = 16'h0490;
      8'h5A: font16 = 16'h0701;
      8'h2D: font16 = 16'h0060;
      default: font16 = 16'h0000;
    endcase
  endfunction

  // characters 1-5 go to the digits, 6-8 to the letter fields
  always_comb begin
    digit_next  = '0;
    letter_next = '0;
    for (int i = 0; i < sld_pkg::NUM_DIGITS; i++) begin
      digit_next[i*8 +: 8] = font7(chars[i*8 +: 8]);
    end
    for (int i = 0; i < sld_pkg::NUM_LETTERS; i++) begin
      letter_next[i*16 +: 16] = font16(chars[(i+5)*8 +: 8]);
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      digit_reg  <= '0;
      letter_reg <= '0;
    end else begin
      digit_reg  <= digit_next;
      letter_reg <= letter_next;
    end
  end

  assign digitPattern  = digit_reg;
  assign letterPattern = letter_reg;
endmodule // sld_font_rom

// >>> hdl/sld_text_driver.sv
// Purpose: segment text_display_write driver with apb register access
// Assumes: 40 MHz ref_clk, synchronous active low resetn, apb master
// Notes:   staged values reach the glass only through a commit write
`timescale 1ns/100ps
module sld_text_driver #(
  parameter int FLASH_HALF_CYCLES = sld_pkg::FLASH_HALF_CYC  // flash half period
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [39:0] digitSeg,
  output logic      [47:0] letterSeg,
  output logic      [7:0]  symbolSeg,
  output logic      [4:0]  pointSeg
);
  // apb slave state
  logic        pready_reg;    // high for the one answering cycle
  logic        pready_next;
  logic        pslverr_reg;   // unmapped address flag
  logic        pslverr_next;
  logic [31:0] prdata_reg;    // captured read data
  logic [31:0] prdata_next;

  // staged values, as written by software
  logic [31:0] textLo_reg;    // characters 1 to 4, char 1 in low byte
  logic [31:0] textLo_next;
  logic [31:0] textHi_reg;    // characters 5 to 8
  logic [31:0] textHi_next;
  logic [3:0]  textLen_reg;   // written length
  logic [3:0]  textLen_next;
  logic [7:0]  flash_reg;     // flash_mask
  logic [7:0]  flash_next;
  logic [7:0]  symbol_reg;    // symbol_mask
  logic [7:0]  symbol_next;
  logic [4:0]  point_reg;     // decimal points, upper bits not kept
  logic [4:0]  point_next;
  logic        pend_reg;      // staged values written since the last commit
  logic        pend_next;

  // committed values, what the glass shows
  logic [63:0] textC_reg;
  logic [63:0] textC_next;
  logic [3:0]  lenC_reg;
  logic [3:0]  lenC_next;
  logic [7:0]  flashC_reg;
  logic [7:0]  flashC_next;
  logic [7:0]  symbolC_reg;
  logic [7:0]  symbolC_next;
  logic [4:0]  pointC_reg;
  logic [4:0]  pointC_next;

  // glass drive registers
  logic [39:0] digitSeg_reg;
  logic [39:0] digitSeg_next;
  logic [47:0] letterSeg_reg;
  logic [47:0] letterSeg_next;
  logic [7:0]  symbolSeg_reg;
  logic [7:0]  symbolSeg_next;
  logic [4:0]  pointSeg_reg;
  logic [4:0]  pointSeg_next;

  // helpers
  logic        accessWait;    // access phase before the answer
  logic        accessDone;    // access phase completing this edge
  logic        wrDone;        // write completing this edge
  logic        commitPulse;   // commit strobe completing this edge
  logic        flashPhase;    // 1 while flashing positions are blank
  logic [63:0] shownChars;    // committed text with unused slots blank
  logic [39:0] digitPattern;  // font output for the digits
  logic [47:0] letterPattern; // font output for the letters

  // address decode, shared by error and write paths
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a == sld_pkg::OFF_TEXT_LO)  || (a == sld_pkg::OFF_TEXT_HI) ||
               (a == sld_pkg::OFF_TEXT_LEN) || (a == sld_pkg::OFF_FLASH)   ||
               (a == sld_pkg::OFF_SYMBOL)   || (a == sld_pkg::OFF_POINT)   ||
               (a == sld_pkg::OFF_COMMIT)   || (a == sld_pkg::OFF_STATUS);
  endfunction

  // merge write data under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        merge[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  assign accessWait  = psel && penable && !pready_reg;
  assign accessDone  = psel && penable && pready_reg;
  assign wrDone      = accessDone && pwrite;
  assign commitPulse = wrDone && (paddr == sld_pkg::OFF_COMMIT) &&
                       pstrb[0] && pwdata[sld_pkg::COMMIT_BIT];

  // apb answer: one wait state, data and error registered on the same edge as pready
  always_comb begin
    pready_next  = accessWait;
    pslverr_next = 1'b0;
    prdata_next  = prdata_reg;
    if (accessWait) begin
      pslverr_next = !isMapped(paddr);
      prdata_next  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          sld_pkg::OFF_TEXT_LO:  prdata_next = textLo_reg;
          sld_pkg::OFF_TEXT_HI:  prdata_next = textHi_reg;
          sld_pkg::OFF_TEXT_LEN: prdata_next[3:0] = textLen_reg;
          sld_pkg::OFF_FLASH:    prdata_next[7:0] = flash_reg;
          sld_pkg::OFF_SYMBOL:   prdata_next[7:0] = symbol_reg;
          sld_pkg::OFF_POINT:    prdata_next[4:0] = point_reg;
          sld_pkg::OFF_STATUS: begin
            prdata_next[sld_pkg::STAT_PHASE] = flashPhase;
            prdata_next[sld_pkg::STAT_PEND]  = pend_reg;
          end
          default: prdata_next = 32'h0000_0000;               // commit, unmapped
        endcase
      end
    end else if (pready_reg) begin
      prdata_next = 32'h0000_0000;                             // clear after answer
    end
  end

  // apb registers only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg  <= prdata_next;
    end
  end

  // staged registers take writes at the completing edge
  always_comb begin
    textLo_next  = textLo_reg;
    textHi_next  = textHi_reg;
    textLen_next = textLen_reg;
    flash_next   = flash_reg;
    symbol_next  = symbol_reg;
    point_next   = point_reg;
    pend_next    = pend_reg;
    if (commitPulse) begin
      pend_next = 1'b0;                                        // cleared by commit
    end
    if (wrDone) begin
      unique case (paddr)
        sld_pkg::OFF_TEXT_LO: textLo_next = merge(textLo_reg, pwdata, pstrb);
        sld_pkg::OFF_TEXT_HI: textHi_next = merge(textHi_reg, pwdata, pstrb);
        sld_pkg::OFF_TEXT_LEN: begin
          if (pstrb[0]) begin
            textLen_next = pwdata[3:0];
          end
        end
        sld_pkg::OFF_FLASH: begin
          if (pstrb[0]) begin
            flash_next = pwdata[7:0];
          end
        end
        sld_pkg::OFF_SYMBOL: begin
          if (pstrb[0]) begin
            symbol_next = pwdata[7:0];
          end
        end
        sld_pkg::OFF_POINT: begin
          if (pstrb[0]) begin
            point_next = pwdata[4:0];
          end
        end
        default: ;                                             // commit, status
      endcase
      if (paddr != sld_pkg::OFF_COMMIT && paddr != sld_pkg::OFF_STATUS &&
          isMapped(paddr)) begin
        pend_next = 1'b1;                                      // set wins
      end
    end
  end

  // commit copies the staged values, otherwise the glass keeps its state
  always_comb begin
    textC_next   = textC_reg;
    lenC_next    = lenC_reg;
    flashC_next  = flashC_reg;
    symbolC_next = symbolC_reg;
    pointC_next  = pointC_reg;
    if (commitPulse) begin
      textC_next   = {textHi_reg, textLo_reg};
      lenC_next    = (textLen_reg > sld_pkg::MAX_LEN) ?
                     sld_pkg::MAX_LEN : textLen_reg;
      flashC_next  = flash_reg;
      symbolC_next = symbol_reg;
      pointC_next  = point_reg;
    end
  end

  // staged and committed registers only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      textLo_reg  <= sld_pkg::RST_TEXT;
      textHi_reg  <= sld_pkg::RST_TEXT;
      textLen_reg <= sld_pkg::RST_LEN;
      flash_reg   <= sld_pkg::RST_MASK;
      symbol_reg  <= sld_pkg::RST_MASK;
      point_reg   <= '0;
      pend_reg    <= 1'b0;
      textC_reg   <= {sld_pkg::RST_TEXT, sld_pkg::RST_TEXT};
      lenC_reg    <= sld_pkg::RST_LEN;
      flashC_reg  <= sld_pkg::RST_MASK;
      symbolC_reg <= sld_pkg::RST_MASK;
      pointC_reg  <= '0;
    end else begin
      textLo_reg  <= textLo_next;
      textHi_reg  <= textHi_next;
      textLen_reg <= textLen_next;
      flash_reg   <= flash_next;
      symbol_reg  <= symbol_next;
      point_reg   <= point_next;
      pend_reg    <= pend_next;
      textC_reg   <= textC_next;
      lenC_reg    <= lenC_next;
      flashC_reg  <= flashC_next;
      symbolC_reg <= symbolC_next;
      pointC_reg  <= pointC_next;
    end
  end

  // positions past the committed length show blank
  always_comb begin
    shownChars = '0;
    for (int i = 0; i < sld_pkg::NUM_CHARS; i++) begin
      shownChars[i*8 +: 8] = (i < int'(lenC_reg)) ?
                             textC_reg[i*8 +: 8] : sld_pkg::CHAR_BLANK;
    end
  end

  // glyph lookup
  sld_font_rom u_font (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .chars         (shownChars),
    .digitPattern  (digitPattern),
    .letterPattern (letterPattern)
  );

  // slow flash phase
  sld_flash_timer #(
    .HALF_CYCLES (FLASH_HALF_CYCLES)
  ) u_flash (
    .ref_clk    (ref_clk),
    .resetn     (resetn),
    .flashPhase (flashPhase)
  );

  // glass words: blank flashing positions in the off phase
  always_comb begin
    digitSeg_next  = digitPattern;
    letterSeg_next = letterPattern;
    for (int d = 0; d < sld_pkg::NUM_DIGITS; d++) begin
      if (flashC_reg[d] && flashPhase) begin
        digitSeg_next[d*8 +: 8] = 8'h00;
      end
    end
    for (int l = 0; l < sld_pkg::NUM_LETTERS; l++) begin
      if (flashC_reg[sld_pkg::NUM_DIGITS + l] && flashPhase) begin
        letterSeg_next[l*16 +: 16] = 16'h0000;
      end
    end
    symbolSeg_next = symbolC_reg;
    pointSeg_next  = pointC_reg;
  end

  // glass registers only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      digitSeg_reg  <= '0;
      letterSeg_reg <= '0;
      symbolSeg_reg <= '0;
      pointSeg_reg  <= '0;
    end else begin
      digitSeg_reg  <= digitSeg_next;
      letterSeg_reg <= letterSeg_next;
      symbolSeg_reg <= symbolSeg_next;
      pointSeg_reg  <= pointSeg_next;
    end
  end

  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign digitSeg  = digitSeg_reg;
  assign letterSeg = letterSeg_reg;
  assign symbolSeg = symbolSeg_reg;
  assign pointSeg  = pointSeg_reg;
endmodule // sld_text_driver

// >>> tb/sld_text_driver_chk.sv
// Purpose: port checker of the segment text_display_write driver
// Assumes: one clock, resetn synchronous active low
// Notes:   helper regs mirror the staged symbol and point bytes
`timescale 1ns/100ps
module sld_text_driver_chk #(
  parameter int FLASH_HALF_CYCLES = 16  // flash half period, unused here
) (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [39:0] digitSeg,
  input wire logic [47:0] letterSeg,
  input wire logic [7:0]  symbolSeg,
  input wire logic [4:0]  pointSeg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic       wrLow;      // write of lane 0 completes
  logic       unmapped;   // address outside the map
  logic       commitHit;  // commit write completes
  logic [7:0] symReg;     // staged symbol byte
  logic [7:0] symNext;
  logic [4:0] ptReg;      // staged point bits, upper bits dropped
  logic [4:0] ptNext;
  assign wrLow = psel && penable && pready && pwrite && pstrb[0];
  assign unmapped = paddr > 8'h1C || paddr[1:0] != 2'h0;
  assign commitHit = wrLow && paddr == sld_pkg::OFF_COMMIT && pwdata[0];
  // next staged values follow completed writes
  always_comb begin
    symNext = symReg;
    ptNext = ptReg;
    if (wrLow && paddr == sld_pkg::OFF_SYMBOL) symNext = pwdata[7:0];
    if (wrLow && paddr == sld_pkg::OFF_POINT) ptNext = pwdata[4:0];
    if (!resetn) begin
      symNext = 8'h00;
      ptNext = 5'h00;
    end
  end
  // register the mirror
  always_ff @(posedge ref_clk) begin
    symReg <= symNext;
    ptReg <= ptNext;
  end
  answer_timing_a:
    assert property (psel && penable && !pready |=> pready && pslverr == $past(unmapped))
    else $error("apb answer or error flag wrong");
  single_ready_a:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  read_idle_a:
    assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
  hold_display_a:
    assert property (!$past(commitHit, 2) |-> $stable(symbolSeg) && $stable(pointSeg))
    else $error("symbols changed without commit");
  symbol_commit_a:
    assert property (commitHit |-> ##2 symbolSeg == $past(symReg, 2)) else $error("symbols wrong");
  point_commit_a:
    assert property (commitHit |-> ##2 pointSeg == $past(ptReg, 2)) else $error("points wrong");
  digit_spare_a:
    assert property ((digitSeg & 40'h20_2020_2020) == 40'h00_0000_0000)
    else $error("unused digit bit driven");
  reset_clear_a:
    assert property ($rose(resetn) |-> !pready && symbolSeg == 8'h00 && digitSeg == 40'h0)
    else $error("outputs not cleared by reset");
  commit_seen_c: cover property (commitHit);
endmodule  // sld_text_driver_chk

bind sld_text_driver sld_text_driver_chk #(.FLASH_HALF_CYCLES(FLASH_HALF_CYCLES)) chk (
  .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .pready, .pslverr, .digitSeg, .letterSeg, .symbolSeg, .pointSeg);

// >>> tb/sld_glass_model.sv
// Purpose: glass model reading digit patterns back as characters
// Assumes: patterns as driven on digitSeg
// Notes:   unreadable patterns show as a question mark
`timescale 1ns/100ps
module sld_glass_model (
  input  wire logic [39:0] digitSeg,
  output logic      [39:0] digitChars
);
  // segment bits e0 f1 d2 g3 a4 c6 b7 back to ascii
  function automatic logic [7:0] readDigit(input logic [7:0] p);
    case (p)
      8'hC0: readDigit = 8'h31;
      8'h9D: readDigit = 8'h32;
      8'hDC: readDigit = 8'h33;
      8'hCA: readDigit = 8'h34;
      8'h5E: readDigit = 8'h35;
      8'hDF: readDigit = 8'h38;
      8'h08: readDigit = 8'h2D;
      8'h00: readDigit = 8'h20;
      default: readDigit = 8'h3F;
    endcase
  endfunction
  // each glass digit read on its own
  always_comb begin
    for (int d = 0; d < 5; d++) digitChars[8*d +: 8] = readDigit(digitSeg[8*d +: 8]);
  end
endmodule  // sld_glass_model

// >>> tb/tb_segment_text_display_write_driver.sv
// Purpose: self-checking bench of the segment text_display_write driver
// Assumes: 40 MHz ref_clk, shortened flash half period
// Notes:   table rows first, then hand-written awkward cases
`timescale 1ns/100ps
module tb_segment_text_display_write_driver;
  localparam int HALF = 16;  // flash half period in clocks
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, symbolSeg;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [39:0] digitSeg, digitChars;
  logic [47:0] letterSeg;
  logic [4:0]  pointSeg;
  int          num_errors, samples_checked, cycles, blank;
  typedef struct packed {
    logic [31:0] lo, hi;
    logic [7:0]  len, sym, pt;
    logic [39:0] dig;
    logic [2:0]  ltr;
    logic [4:0]  ptx;
  } sld_row_t;
  // ascii text as the host prepares it
  sld_row_t rows[4] = '{
    '{32'h3433_3231, 32'h4342_4135, 8'h08, 8'h01, 8'hFF, 40'h35_3433_3231, 3'h7, 5'h1F},
    '{32'h3433_3231, 32'h4342_4135, 8'h03, 8'h80, 8'hE0, 40'h20_2033_3231, 3'h0, 5'h00},
    '{32'h382D_382D, 32'h5A59_582D, 8'h0F, 8'h55, 8'h0A, 40'h2D_382D_382D, 3'h7, 5'h0A},
    '{32'h3433_3231, 32'h4342_4135, 8'h00, 8'hAA, 8'h15, 40'h20_2020_2020, 3'h0, 5'h15}};
  sld_text_driver #(.FLASH_HALF_CYCLES(HALF)) uut (.ref_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .digitSeg, .letterSeg,
    .symbolSeg, .pointSeg);
  sld_glass_model glass (.digitSeg, .digitChars);
  // free running clock
  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // compare and count
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, result left in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // answer looked at mid-cycle, where it has settled; the wait ends on pready, a hung one only at the hang guard
    do begin
      @(negedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // commit, then let the font stage settle
  task automatic commit;
    apb(1'b1, sld_pkg::OFF_COMMIT, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
  endtask
  // reports counts and ends the run
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    num_errors = 0;
    samples_checked = 0;
    cycles = 0;
    {psel, penable, pwrite, resetn} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    check({symbolSeg, pointSeg, digitSeg, letterSeg}, 64'h0);
    apb(1'b0, sld_pkg::OFF_TEXT_LO, 32'h0000_0000);
    check(rd, sld_pkg::RST_TEXT);
    // table of texts, symbols and points
    foreach (rows[i]) begin
      apb(1'b1, sld_pkg::OFF_TEXT_LO, rows[i].lo);
      apb(1'b1, sld_pkg::OFF_TEXT_HI, rows[i].hi);
      apb(1'b1, sld_pkg::OFF_TEXT_LEN, {24'h0, rows[i].len});
      apb(1'b1, sld_pkg::OFF_SYMBOL, {24'h0, rows[i].sym});
      apb(1'b1, sld_pkg::OFF_POINT, {24'h0, rows[i].pt});
      commit();
      check(digitChars, rows[i].dig);
      check({|letterSeg[47:32], |letterSeg[31:16], |letterSeg[15:0]}, rows[i].ltr);
      check(symbolSeg, rows[i].sym);
      check({er, pointSeg}, rows[i].ptx);
    end
    // staged values and a commit write with bit 0 clear change nothing
    apb(1'b1, sld_pkg::OFF_SYMBOL, 32'h0000_000F);
    apb(1'b1, sld_pkg::OFF_COMMIT, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    check(symbolSeg, 8'hAA);
    apb(1'b0, sld_pkg::OFF_STATUS, 32'h0000_0000);
    check(rd[sld_pkg::STAT_PEND], 1'b1);
    // unmapped and misaligned addresses, read of the commit word
    apb(1'b0, 8'h40, 32'h0000_0000);
    check({er, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 8'h02, 32'h0000_0000);
    check(er, 1'b1);
    apb(1'b0, sld_pkg::OFF_COMMIT, 32'h0000_0000);
    check({er, rd}, 33'h0);
    // flash masks: each flagged position blanks half of a 64 cycle window, unflagged ones never
    apb(1'b1, sld_pkg::OFF_TEXT_LO, rows[0].lo);
    apb(1'b1, sld_pkg::OFF_TEXT_HI, rows[0].hi);
    apb(1'b1, sld_pkg::OFF_TEXT_LEN, 32'h0000_0008);
    foreach (rows[m]) begin
      if (m < 2) begin
        apb(1'b1, sld_pkg::OFF_FLASH, m == 0 ? 32'h0000_0081 : 32'h0000_007E);
        commit();
        check(rd, 32'h0000_0000);
        for (int p = 0; p < 8; p++) begin
          blank = 0;
          repeat (4 * HALF) begin
            @(negedge ref_clk);
            blank += (p < 5 ? digitSeg[8*p +: 8] == 8'h00 : letterSeg[16*(p-5) +: 16] == 0);
          end
          check(blank, ((m == 0 ? 8'h81 : 8'h7E) >> p) & 1 ? 2 * HALF : 0);
        end
      end
    end
    apb(1'b0, sld_pkg::OFF_STATUS, 32'h0000_0000);
    check(rd[sld_pkg::STAT_PEND], 1'b0);
    // reset in mid run clears the glass
    resetn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    check({symbolSeg, pointSeg, digitSeg}, 53'h0);
    results();
  end
endmodule  // tb_segment_text_display_write_driver
